// >>> hw/sdl_link.sv
// Embedded-clock serializer and deserializer with APB control
// Functional notes
// - Parallel outputs update in three 8-bit banks, each one step after the last.
// - The serializer embeds its clock in the stream and carries 24 data bits per frame.
// - The deserializer tracks the embedded clock bits and raises link acquired on lock.
// - With tx edge select high, input words are captured on the rising parallel clock edge.
// - With rx edge select high, output data is stable at the recovered clock's rising edge.
// - The deserializer locks onto a live random stream with no training or reference.
// - Each frame is 28 serial bits: 24 data bits plus 4 clock bits.
// - A missed clock edge drops link acquired and restarts the lock search.
// - Serial outputs float on low output enable, low power-down, or unlocked tx PLL.
// - Rx output enable low floats data and clock, lock still shows; power-down floats all.
module sdl_link
	import sdl_pkg::*;
#(
	parameter int LOCK_N  = LOCK_FRAMES,
	parameter int TX_EDGS = TX_LOCK_EDGES
) (
	// APB
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	// Serializer pins
	input  wire logic              tx_parallel_clock,
	input  wire logic              tx_edge_select,
	input  wire logic              tx_output_enable,
	input  wire logic              tx_power_down_n,
	input  wire logic [DATA_W-1:0] tx_data,
	output logic                   serial_out_p,
	output logic                   serial_out_n,
	output logic                   serial_out_oe,
	// Deserializer pins
	input  wire logic              serial_in_pair,
	input  wire logic              rx_edge_select,
	input  wire logic              rx_output_enable,
	input  wire logic              rx_power_down_n,
	output logic      [DATA_W-1:0] parallel_out,
	output logic                   parallel_out_oe,
	output logic                   rx_clock_out,
	output logic                   rx_clock_oe,
	output logic                   link_acquired,
	output logic                   link_acquired_oe
);

	// ==========================================================
	// Pin synchronisation
	sdl_pins_s raw;
	sdl_pins_s syn;

	assign raw = {tx_parallel_clock, tx_edge_select, tx_output_enable,
		tx_power_down_n, rx_edge_select, rx_output_enable,
		rx_power_down_n, serial_in_pair, tx_data};

	sdl_sync #(.W($bits(sdl_pins_s))) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (raw),
		.q     (syn)
	);

	// ==========================================================
	// Serializer
	localparam int TXW = $clog2(TX_EDGS + 1);

	logic                  txc_q;
	logic                  tx_rise;
	logic                  tx_cap;
	logic                  tx_run;
	logic                  tx_pll_r;
	logic [TXW-1:0]        tx_lk_cnt_r;
	logic [DATA_W-1:0]     tx_word_r;
	logic [4:0]            tx_cnt_r;
	logic [FRAME_BITS-1:0] tx_sh_r;
	logic [FRAME_BITS-1:0] tx_frame;
	logic                  tx_bit;
	logic                  ev_tx_pll;

	assign tx_rise   = syn.tx_clk & ~txc_q;
	assign tx_cap    = syn.tx_sel ? tx_rise : (~syn.tx_clk & txc_q);
	assign tx_run    = syn.tx_pd_n & tx_pll_r;
	assign tx_frame  = {CLK_TAIL, tx_word_r, CLK_HEAD};
	assign tx_bit    = (tx_cnt_r == 5'h00) ? tx_frame[0] : tx_sh_r[0];
	assign ev_tx_pll = syn.tx_pd_n & tx_rise & ~tx_pll_r &
		(tx_lk_cnt_r == TXW'(TX_EDGS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_q <= 1'b0;
		end else begin
			txc_q <= syn.tx_clk;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pll_r    <= 1'b0;
			tx_lk_cnt_r <= '0;
		end else if (!syn.tx_pd_n) begin
			tx_pll_r    <= 1'b0;
			tx_lk_cnt_r <= '0;
		end else if (ev_tx_pll) begin
			tx_pll_r    <= 1'b1;
		end else if (tx_rise && !tx_pll_r) begin
			tx_lk_cnt_r <= tx_lk_cnt_r + TXW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_word_r <= '0;
		end else if (tx_cap) begin
			tx_word_r <= syn.tx_data;
		end
	end

	// Frames run back to back; the newest captured word goes out next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt_r      <= 5'h00;
			tx_sh_r       <= '0;
			serial_out_p  <= 1'b0;
			serial_out_n  <= 1'b1;
			serial_out_oe <= 1'b0;
		end else begin
			serial_out_oe <= tx_run & syn.tx_oe;
			serial_out_p  <= tx_run & tx_bit;
			serial_out_n  <= ~(tx_run & tx_bit);
			if (!tx_run) begin
				tx_cnt_r <= 5'h00;
				tx_sh_r  <= '0;
			end else begin
				tx_sh_r  <= ((tx_cnt_r == 5'h00) ? tx_frame : tx_sh_r) >> 1;
				tx_cnt_r <= (tx_cnt_r == 5'(FRAME_BITS - 1)) ? 5'h00 :
					tx_cnt_r + 5'h01;
			end
		end
	end

	tx_float_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(tx_run && syn.tx_oe) |=> !serial_out_oe)
		else $error("serial output driven while it should float");
	tx_head_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_run && tx_cnt_r == 5'h00) |=> serial_out_p)
		else $error("frame does not open with a clock bit");
	tx_tail_a: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_run && tx_cnt_r == 5'(FRAME_BITS - 2)) |=> !serial_out_p [*2])
		else $error("frame does not close with two low clock bits");
	tx_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		(syn.tx_sel && tx_rise) |=> tx_word_r == $past(syn.tx_data))
		else $error("word not captured on rising parallel clock");

	// ==========================================================
	// Deserializer lock search
	localparam int GW = $clog2(LOCK_N + 1);

	sdl_rx_e               rx_st_r;
	logic [FRAME_BITS-1:0] rx_sh_r;
	logic [4:0]            rx_cnt_r;
	logic [4:0]            rx_cnt_nxt;
	logic [GW-1:0]         rx_good_r;
	logic [DATA_W-1:0]     rx_word_r;
	logic                  rx_match;
	logic                  rx_tick;
	logic                  rx_locked;
	logic                  relock;

	assign rx_match   = (rx_sh_r[1:0] == CLK_HEAD) &&
		(rx_sh_r[FRAME_BITS-1 -: 2] == CLK_TAIL);
	assign rx_tick    = (rx_cnt_r == 5'h00);
	assign rx_locked  = (rx_st_r == RX_LOCKED);
	assign rx_cnt_nxt = (rx_cnt_r == 5'(FRAME_BITS - 1)) ? 5'h00 :
		rx_cnt_r + 5'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_r <= '0;
		end else begin
			rx_sh_r <= {syn.ser_in, rx_sh_r[FRAME_BITS-1:1]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r   <= RX_HUNT;
			rx_cnt_r  <= 5'h00;
			rx_good_r <= '0;
		end else if (!syn.rx_pd_n || relock) begin
			rx_st_r   <= RX_HUNT;
			rx_cnt_r  <= 5'h00;
			rx_good_r <= '0;
		end else begin
			unique case (rx_st_r)
				RX_HUNT: begin
					if (rx_match) begin
						rx_st_r   <= RX_VERIFY;
						rx_cnt_r  <= 5'h01;
						rx_good_r <= GW'(1);
					end
				end
				RX_VERIFY: begin
					rx_cnt_r <= rx_cnt_nxt;
					if (rx_tick && !rx_match) begin
						rx_st_r <= RX_HUNT;
					end else if (rx_tick) begin
						rx_good_r <= rx_good_r + GW'(1);
						if (rx_good_r == GW'(LOCK_N - 1)) begin
							rx_st_r <= RX_LOCKED;
						end
					end
				end
				RX_LOCKED: begin
					rx_cnt_r <= rx_cnt_nxt;
					if (rx_tick && !rx_match) begin
						rx_st_r <= RX_HUNT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_word_r <= '0;
		end else if (rx_st_r != RX_HUNT && rx_tick && rx_match) begin
			rx_word_r <= rx_sh_r[DATA_W+1:2];
		end
	end

	// ==========================================================
	// Deserializer outputs
	logic [4:0]       bank_pt;
	logic [BANKS-1:0] bank_go;

	assign bank_pt = syn.rx_sel ? 5'(HALF_FRAME) : 5'(RX_EARLY);

	genvar gi;
	for (gi = 0; gi < BANKS; gi++) begin : g_bank
		assign bank_go[gi] = rx_locked &&
			(rx_cnt_r == bank_pt + 5'(gi * STAGGER_CYC));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				parallel_out[gi*BANK_W +: BANK_W] <= '0;
			end else if (bank_go[gi]) begin
				parallel_out[gi*BANK_W +: BANK_W] <=
					rx_word_r[gi*BANK_W +: BANK_W];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_clock_out     <= 1'b0;
			rx_clock_oe      <= 1'b0;
			parallel_out_oe  <= 1'b0;
			link_acquired    <= 1'b0;
			link_acquired_oe <= 1'b0;
		end else begin
			rx_clock_out     <= rx_locked &&
				((rx_cnt_r < 5'(HALF_FRAME)) == syn.rx_sel);
			rx_clock_oe      <= syn.rx_pd_n & syn.rx_oe & rx_locked;
			parallel_out_oe  <= syn.rx_pd_n & syn.rx_oe & rx_locked;
			link_acquired    <= rx_locked;
			link_acquired_oe <= syn.rx_pd_n;
		end
	end

	lock_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(link_acquired) |-> $past(rx_st_r, 2) == RX_VERIFY)
		else $error("link acquired rose without frame verification");
	lock_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_locked && rx_tick && !rx_match) |-> ##2 !link_acquired)
		else $error("missed clock edge did not drop link acquired");
	hunt_catch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_st_r == RX_HUNT && rx_match && syn.rx_pd_n && !relock)
		|=> rx_st_r == RX_VERIFY)
		else $error("search ignored a candidate clock pattern");
	bank_step_a: assert property (@(posedge pclk)
		disable iff (!presetn || !syn.rx_pd_n || relock)
		bank_go[0] |=> bank_go[1] ##1 bank_go[2])
		else $error("output banks not staggered one step apart");
	rclk_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bank_go[0] && syn.rx_sel) |=> !rx_clock_out)
		else $error("data switched while recovered clock was high");
	rx_float_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(syn.rx_pd_n && syn.rx_oe) |=>
		!parallel_out_oe && !rx_clock_oe &&
		link_acquired_oe == $past(syn.rx_pd_n))
		else $error("deserializer outputs not floated as required");

	// ==========================================================
	// APB registers and interrupt
	logic             acc;
	logic             wr_done;
	logic             rd_done;
	logic [IRQ_W-1:0] int_st_r;
	logic [IRQ_W-1:0] int_msk_r;
	logic [IRQ_W-1:0] int_ev;
	logic [IRQ_W-1:0] int_clr;
	logic [31:0]      rd_val;
	logic             rd_hit;

	assign acc     = psel & penable;
	assign wr_done = acc & pready & pwrite;
	assign rd_done = acc & pready & ~pwrite;
	assign relock  = wr_done && paddr == OFS_CTRL && pwdata[CTRL_RELOCK];
	// Clear only the bits that the read returned, so that an event landing
	// between the data capture and the clear is not lost
	assign int_clr = (rd_done && paddr == OFS_INT_ST) ?
		prdata[IRQ_W-1:0] : '0;

	always_comb begin
		int_ev             = '0;
		int_ev[IRQ_ACQ]    = rx_locked & ~link_acquired;
		int_ev[IRQ_LOST]   = ~rx_locked & link_acquired;
		int_ev[IRQ_TX_PLL] = ev_tx_pll;
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (paddr)
			OFS_CTRL:    rd_val = 32'h0000_0000;
			OFS_STATUS: begin
				rd_val[ST_LOCK]   = link_acquired;
				rd_val[ST_TX_PLL] = tx_pll_r;
			end
			OFS_INT_ST:  rd_val[IRQ_W-1:0] = int_st_r;
			OFS_INT_MSK: rd_val[IRQ_W-1:0] = int_msk_r;
			OFS_RX_WORD: rd_val[DATA_W-1:0] = rx_word_r;
			default:     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc & ~pready;
			if (acc && !pready) begin
				prdata  <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= ~rd_hit;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_msk_r <= MASK_RST;
		end else if (wr_done && paddr == OFS_INT_MSK) begin
			int_msk_r <= pwdata[IRQ_W-1:0];
		end
	end

	// A new event in the clearing cycle survives the read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_st_r <= '0;
			irq      <= 1'b0;
		end else begin
			int_st_r <= (int_st_r & ~int_clr) | int_ev;
			irq      <= |(int_st_r & int_msk_r);
		end
	end

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(int_st_r & int_msk_r)) |=> irq)
		else $error("unmasked status bit did not raise the interrupt");
	int_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(int_ev[IRQ_LOST] && int_clr[IRQ_LOST]) |=> int_st_r[IRQ_LOST])
		else $error("event lost in the cycle it was cleared");

endmodule

// >>> hw/sdl_pkg.sv
// Shared constants, types and register map of the serial link block
package sdl_pkg;

	// ==========================================================
	// Frame layout
	localparam int          DATA_W      = 24;
	localparam int          CTL_BITS    = 4;
	localparam int          FRAME_BITS  = DATA_W + CTL_BITS;
	localparam int          HALF_FRAME  = FRAME_BITS / 2;
	localparam int          BANK_W      = 8;
	localparam int          BANKS       = DATA_W / BANK_W;
	localparam logic [1:0]  CLK_HEAD    = 2'h3;
	localparam logic [1:0]  CLK_TAIL    = 2'h0;

	// ==========================================================
	// Timing (one serial bit per pclk cycle)
	localparam int          PCLK_HZ     = 10_000_000;
	localparam int          UI_CYCLES   = 1;
	localparam int          STAGGER_CYC = (UI_CYCLES + 1) / 2;
	localparam int          RX_EARLY    = 1;
	localparam int          LOCK_FRAMES = 4;
	localparam int          TX_LOCK_EDGES = 16;

	// ==========================================================
	// Register map
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_INT_ST  = 12'h008;
	localparam logic [11:0] OFS_INT_MSK = 12'h00c;
	localparam logic [11:0] OFS_RX_WORD = 12'h010;
	localparam int          CTRL_RELOCK = 0;
	localparam int          ST_LOCK     = 0;
	localparam int          ST_TX_PLL   = 1;
	localparam int          IRQ_ACQ     = 0;
	localparam int          IRQ_LOST    = 1;
	localparam int          IRQ_TX_PLL  = 2;
	localparam int          IRQ_W       = 3;
	localparam logic [2:0]  MASK_RST    = 3'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {RX_HUNT, RX_VERIFY, RX_LOCKED} sdl_rx_e;

	typedef struct packed {
		logic              tx_clk;
		logic              tx_sel;
		logic              tx_oe;
		logic              tx_pd_n;
		logic              rx_sel;
		logic              rx_oe;
		logic              rx_pd_n;
		logic              ser_in;
		logic [DATA_W-1:0] tx_data;
	} sdl_pins_s;

endpackage

// >>> hw/sdl_sync.sv
// Two-flop synchroniser for a vector of independent levels
module sdl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// >>> sim/sdl_host_model.sv
// Host model: parallel clock and word source for the serializer
module sdl_host_model
	import sdl_pkg::*;
(
	// Control from the bench
	input  wire logic              run,
	input  wire logic              sel,
	input  wire logic [DATA_W-1:0] word,
	// Parallel side of the serializer
	output logic                   tx_clk,
	output logic      [DATA_W-1:0] tx_data
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Word is valid only around the selected edge, a decoy elsewhere
	initial begin
		tx_clk = 1'b0;
		tx_data = '0;
		#37;
		forever begin
			if (run) begin
				tx_clk = 1'b1;
				#200 tx_data = sel ? ~word : word;
				#200 tx_clk = 1'b0;
				#200 tx_data = sel ? word : ~word;
				#200;
			end else begin
				#100;
			end
		end
	end
endmodule

// >>> sim/sdl_link_tb_top.sv
// Testbench for the serial link block
module sdl_link_tb_top
	import sdl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	localparam logic [23:0] W1 = {3'h5, 3'h5, 6'h1c, 6'h33, 6'h0f};
	localparam logic [23:0] W2 = 24'h1e2d3c;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic        rerr, run, tx_parallel_clock, tx_edge_select;
	logic        tx_output_enable, tx_power_down_n, serial_out_p;
	logic        serial_out_n, serial_out_oe, serial_in_pair;
	logic        rx_edge_select, rx_output_enable, rx_power_down_n;
	logic        parallel_out_oe, rx_clock_out, rx_clock_oe;
	logic        link_acquired, link_acquired_oe;
	logic [23:0] tx_data, parallel_out, word;
	int          fail_count, comparisons;

	sdl_link u_sdl_link (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .irq, .tx_parallel_clock,
		.tx_edge_select, .tx_output_enable, .tx_power_down_n, .tx_data,
		.serial_out_p, .serial_out_n, .serial_out_oe, .serial_in_pair,
		.rx_edge_select, .rx_output_enable, .rx_power_down_n, .parallel_out,
		.parallel_out_oe, .rx_clock_out, .rx_clock_oe, .link_acquired,
		.link_acquired_oe);
	sdl_host_model u_sdl_host_model (.run, .sel(tx_edge_select), .word,
		.tx_clk(tx_parallel_clock), .tx_data);

	// Loopback; a floated line toggles every cycle
	always @(posedge pclk)
		serial_in_pair <= serial_out_oe ? serial_out_p : ~serial_in_pair;

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========================================================
	// Shared tasks
	task check(input string nm, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait for the answer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
		apb(1'b0, a, 32'h0);
		check($sformatf("read %h", a), rdata, e);
		check("pslverr", {31'h0, rerr}, {31'h0, er});
	endtask

	task wait_lock(input logic v);
		int n;
		n = 0;
		while (link_acquired !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		check("link_acquired", {31'h0, link_acquired}, {31'h0, v});
	endtask

	task settle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// ==========================================================
	// Scenarios
	task t_regs;
		rd(OFS_STATUS, 32'h0, 1'b0);
		rd(OFS_INT_MSK, {29'h0, MASK_RST}, 1'b0);
		apb(1'b1, OFS_INT_MSK, 32'h7);
		rd(OFS_INT_MSK, 32'h7, 1'b0);
		rd(12'h014, 32'h0, 1'b1);
		check("irq", {31'h0, irq}, 32'h0);
	endtask

	task t_lock;
		run <= 1'b1;
		wait_lock(1'b1);
		settle(2 * FRAME_BITS);
		check("parallel_out", {8'h0, parallel_out}, {8'h0, W1});
		rd(OFS_RX_WORD, {8'h0, W1}, 1'b0);
		rd(OFS_STATUS, 32'h3, 1'b0);
		check("irq", {31'h0, irq}, 32'h1);
		rd(OFS_INT_ST, 32'h5, 1'b0);
		settle(2);
		check("irq", {31'h0, irq}, 32'h0);
		check("oe", {30'h0, parallel_out_oe, link_acquired_oe}, 32'h3);
	endtask

	task t_stagger;
		int n;
		word <= W2;
		n = 0;
		while (parallel_out[7:0] === W1[7:0] && n < 300) begin
			@(posedge pclk);
			n++;
		end
		check("bank0", {8'h0, parallel_out}, {8'h0, W1[23:8], W2[7:0]});
		@(posedge pclk);
		check("bank1", {8'h0, parallel_out}, {8'h0, W1[23:16], W2[15:0]});
		@(posedge pclk);
		check("bank2", {8'h0, parallel_out}, {8'h0, W2});
	endtask

	task t_rxclk;
		time t0;
		for (int s = 1; s >= 0; s--) begin
			rx_edge_select <= s[0];
			settle(2 * FRAME_BITS);
			@(posedge rx_clock_out);
			t0 = $time;
			check("strobe", {8'h0, parallel_out}, {8'h0, W2});
			@(posedge rx_clock_out);
			check("frame", 32'(($time - t0) / 100), FRAME_BITS);
		end
		rx_edge_select <= 1'b1;
	endtask

	task t_loss;
		apb(1'b1, OFS_INT_MSK, 32'h1);
		tx_output_enable <= 1'b0;
		settle(4);
		check("serial_out_oe", {31'h0, serial_out_oe}, 32'h0);
		wait_lock(1'b0);
		settle(3);
		check("parallel_out_oe", {31'h0, parallel_out_oe}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		rd(OFS_INT_ST, 32'h2, 1'b0);
		tx_output_enable <= 1'b1;
		wait_lock(1'b1);
		settle(3);
		check("irq", {31'h0, irq}, 32'h1);
		rd(OFS_INT_ST, 32'h1, 1'b0);
	endtask

	task t_power;
		rx_output_enable <= 1'b0;
		settle(4);
		check("rx float", {29'h0, parallel_out_oe, rx_clock_oe,
			link_acquired}, 32'h1);
		rx_output_enable <= 1'b1;
		rx_power_down_n <= 1'b0;
		settle(4);
		check("lock oe", {31'h0, link_acquired_oe}, 32'h0);
		rx_power_down_n <= 1'b1;
		tx_power_down_n <= 1'b0;
		settle(4);
		check("tx float", {30'h0, serial_out_oe, serial_out_n}, 32'h1);
		rd(OFS_STATUS, 32'h0, 1'b0);
		tx_edge_select <= 1'b0;
		word <= W1;
		tx_power_down_n <= 1'b1;
	endtask

	task t_txedge;
		wait_lock(1'b1);
		settle(2 * FRAME_BITS);
		rd(OFS_RX_WORD, {8'h0, W1}, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_lock(1'b0);
		wait_lock(1'b1);
		rd(OFS_CTRL, 32'h0, 1'b0);
	endtask

	// ==========================================================
	// Sequence, watchdog and verdict
	task wrap_up;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, run, serial_in_pair} = '0;
		{paddr, pwdata} = '0;
		{tx_edge_select, tx_output_enable, tx_power_down_n} = 3'h7;
		{rx_edge_select, rx_output_enable, rx_power_down_n} = 3'h7;
		word = W1;
		fail_count = 0;
		comparisons = 0;
		settle(10);
		presetn <= 1'b1;
		t_regs();
		t_lock();
		t_stagger();
		t_rxclk();
		t_loss();
		t_power();
		t_txedge();
		wrap_up();
	end

	initial begin
		#3_000_000;
		fail_count++;
		$display("[FAIL] watchdog expected done seen hang");
		wrap_up();
	end
endmodule
